// [hdl/dpl_pkg.sv]
// Purpose: shared constants and types of the digital loop control block
// Assumes: CLK_I is the internal resonator reference at 25 MHz
// Notes: byte offsets of the APB register map live here
package dpl_pkg;

   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned SKIP_TIMEOUT_US = 20_000;
   localparam int unsigned SKIP_CYCLES =
      SKIP_TIMEOUT_US * (CLK_HZ / 1_000_000);
   localparam int unsigned HOLD_LOG2 = 23;
   localparam int unsigned HOLD_CYCLES = 1 << HOLD_LOG2;

   localparam int CNT_W = 24;
   localparam int RATIO_W = 32;
   localparam int ADDR_W = 8;
   localparam int BW_W = 3;

   localparam logic [7:0] OFF_CFG = 8'h00;
   localparam logic [7:0] OFF_RATIO0 = 8'h04;
   localparam logic [7:0] OFF_RATIO1 = 8'h08;
   localparam logic [7:0] OFF_RATIO2 = 8'h0c;
   localparam logic [7:0] OFF_RATIO3 = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;
   localparam logic [7:0] OFF_NVAL = 8'h18;
   localparam logic [7:0] OFF_PERIOD = 8'h1c;

   localparam int CFG_SKIP_BIT = 0;
   localparam int CFG_OWU_BIT = 1;
   localparam int CFG_BW_LSB = 4;
   localparam int ST_LOCK_BIT = 0;
   localparam int ST_OUT_BIT = 1;
   localparam int ST_MODE_LSB = 2;
   localparam int ST_STATE_LSB = 4;
   localparam int ST_SHIFT_LSB = 8;

   localparam logic [31:0] RATIO_RST = 32'h0010_0000;
   localparam logic [3:0] LOCK_GOOD = 4'h8;
   localparam int LOCK_TOL_SH = 6;
   localparam int GLITCH_SH = 3;
   localparam int GAP_SH = 1;
   localparam logic [3:0] BW_SHIFT_MAX = 4'h8;
   localparam logic [3:0] ACQ_SHIFT = 4'h0;
   localparam logic [5:0] DIV_STEPS = 6'h20;

   typedef enum logic [3:0] {
      ST_ACQ = 4'b0001,
      ST_LOCK = 4'b0010,
      ST_GAP = 4'b0100,
      ST_EXP = 4'b1000
   } dpl_state_t;

endpackage : dpl_pkg

// [hdl/dpl_div.sv]
// Purpose: sequential restoring divider, ratio over measured period
// Assumes: divisor is never zero while start_i is high
// Notes: done_o pulses one cycle, 33 cycles after start_i
`timescale 1ns/1ps
`default_nettype none
module dpl_div (
   input wire logic clk_i, // resonator clock
   input wire logic srst_i, // synchronous reset
   input wire logic start_i, // begin a division
   input wire logic [31:0] dividend_i, // desired ratio
   input wire logic [23:0] divisor_i, // reference period
   output logic [31:0] quotient_o, // result
   output logic done_o // result valid pulse
);

   typedef struct packed {
      logic busy;
      logic done;
      logic [5:0] cnt;
      logic [24:0] rem;
      logic [31:0] dvd;
      logic [23:0] dvs;
      logic [31:0] quo;
   } dpl_div_st_t;

   dpl_div_st_t q, d;
   logic [24:0] rem_sh;

   always_comb begin
      d = q;
      d.done = 1'b0;
      rem_sh = {q.rem[23:0], q.dvd[31]};
      if (start_i) begin
         d.busy = 1'b1;
         d.cnt = '0;
         d.rem = '0;
         d.dvd = dividend_i;
         d.dvs = divisor_i;
         d.quo = '0;
      end else if (q.busy) begin
         d.dvd = {q.dvd[30:0], 1'b0};
         if (rem_sh >= {1'b0, q.dvs}) begin
            d.rem = rem_sh - {1'b0, q.dvs};
            d.quo = {q.quo[30:0], 1'b1};
         end else begin
            d.rem = rem_sh;
            d.quo = {q.quo[30:0], 1'b0};
         end
         d.cnt = q.cnt + 6'h01;
         if (q.cnt == dpl_pkg::DIV_STEPS - 6'h01) begin
            d.busy = 1'b0;
            d.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign quotient_o = q.quo;
   assign done_o = q.done;

endmodule : dpl_div
`default_nettype wire

// [hdl/dpl_ctrl.sv]
// Purpose: digital loop control: ratio, divide value N, lock and skip
// Assumes: CLK_I is the internal resonator reference, 25 MHz
// Notes: APB3 slave, registers answer with no wait cycle
`timescale 1ns/1ps
`default_nettype none
// How it works
// [R1] measure ratio, compare, produce N
// [R2] resonator drift removed by period remeasure
// [R3] convert reference ratio to resonator ratio
// [R4] mode pins pick ratio and set
// [R5] global settings unaffected by mode pins
// [R6] skip enable holds lock across gaps
// [R7] skipping only for reference below 80 kHz; the reference rate is not checked here, skip_en alone allows it
// [R8] output runs 2^23 cycles after stop
// [R9] period change as it stops unlocks immediately
// [R10] hold timeout declares unlock, output per setting
// [R11] late return: reacquire, then resume output
// [R12] return before timeout, after skip: reacquire
// [R13] quick return without skip: reacquire unlocked
// [R14] quick return with skip: output continuous
// [R15] minimum bandwidth from three-bit select
// [R16] jitter above corner attenuated, below passed
// [R17] wide bandwidth while acquiring, then settle
// [R18] system picks lowest bandwidth avoiding wander
// [R19] lock within 200 periods or 3 ms
// [R20] hold counter restarts on every reference edge
module dpl_ctrl #(
   parameter int unsigned HOLD_CYCLES = dpl_pkg::HOLD_CYCLES,
   parameter int unsigned SKIP_CYCLES = dpl_pkg::SKIP_CYCLES
) (
   input wire logic CLK_I, // resonator reference clock
   input wire logic SRST_I, // synchronous reset, high
   input wire logic REF_CLK_I, // reference clock pin
   input wire logic [1:0] MODE_SEL_I, // mode select pins
   input wire logic PSEL_I, // apb select
   input wire logic PENABLE_I, // apb enable
   input wire logic PWRITE_I, // apb direction
   input wire logic [7:0] PADDR_I, // apb byte address
   input wire logic [31:0] PWDATA_I, // apb write data
   output logic [31:0] PRDATA_O, // apb read data
   output logic PREADY_O, // apb ready
   output logic PSLVERR_O, // apb error, unmapped
   output logic [31:0] N_VALUE_O, // divide value to synthesizer
   output logic LOCKED_O, // loop locked
   output logic OUT_EN_O // synthesized output enable
);

   // limits cut to the width of the gap counter
   localparam logic [23:0] HOLD_L = 24'(HOLD_CYCLES - 1);
   localparam logic [23:0] SKIP_L = 24'(SKIP_CYCLES);

   typedef struct packed {
      logic [2:0] ref_s;
      logic [1:0] mode_m;
      logic [1:0] mode_s;
      logic [1:0] mode_prev;
      dpl_pkg::dpl_state_t state;
      logic [23:0] since;
      logic [23:0] period;
      logic have_prev;
      logic [31:0] n;
      logic [31:0] target;
      logic [3:0] shift;
      logic [3:0] good;
      logic skip_en;
      logic owu;
      logic [2:0] bw_sel;
      logic [3:0][31:0] ratio;
      logic div_start;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic locked;
      logic out_en;
   } dpl_ctrl_st_t;

   dpl_ctrl_st_t q, d;

   function automatic logic [3:0] min_shift(input logic [2:0] sel);
      min_shift = dpl_pkg::BW_SHIFT_MAX - {1'b0, sel};
   endfunction : min_shift

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == dpl_pkg::OFF_CFG) || (a == dpl_pkg::OFF_RATIO0) ||
         (a == dpl_pkg::OFF_RATIO1) || (a == dpl_pkg::OFF_RATIO2) ||
         (a == dpl_pkg::OFF_RATIO3) || (a == dpl_pkg::OFF_STATUS) ||
         (a == dpl_pkg::OFF_NVAL) || (a == dpl_pkg::OFF_PERIOD);
   endfunction : mapped

   logic div_done;
   logic [31:0] div_quo;
   logic ref_edge;
   logic [23:0] meas;
   logic [24:0] tol_lo;
   logic [24:0] tol_hi;
   logic [24:0] gap_lim;
   logic glitch;
   logic [31:0] ratio_sel;
   logic [55:0] meas_ratio;
   logic [55:0] ratio_err;
   logic in_tol;
   logic [32:0] step;
   logic [32:0] nsum;
   logic [31:0] status;
   logic [31:0] cfg_word;
   logic [3:0] min_sh;

   // one division per measured period, result 34 cycles after the edge
   dpl_div u_div (
      .clk_i(CLK_I),
      .srst_i(SRST_I),
      .start_i(q.div_start),
      .dividend_i(ratio_sel),
      .divisor_i(q.period),
      .quotient_o(div_quo),
      .done_o(div_done)
   );

   always_comb begin
      d = q;
      d.div_start = 1'b0;
      // two-stage sync on the pins, third stage for edge detect
      d.ref_s = {q.ref_s[1:0], REF_CLK_I};
      d.mode_m = MODE_SEL_I;
      d.mode_s = q.mode_m;
      d.mode_prev = q.mode_s;
      ref_edge = q.ref_s[1] & ~q.ref_s[2];
      ratio_sel = q.ratio[q.mode_s]; // R4
      min_sh = min_shift(q.bw_sel); // R15
      meas = (q.since == '1) ? q.since : q.since + 24'h000001;
      d.since = ref_edge ? '0 : meas; // R20
      // window that tells a glitch from a clean stop
      tol_lo = {1'b0, q.period} - ({1'b0, q.period} >> dpl_pkg::GLITCH_SH);
      tol_hi = {1'b0, q.period} + ({1'b0, q.period} >> dpl_pkg::GLITCH_SH);
      gap_lim = {1'b0, q.period} + ({1'b0, q.period} >> dpl_pkg::GAP_SH);
      glitch = q.have_prev &&
         (({1'b0, meas} < tol_lo) || ({1'b0, meas} > tol_hi));
      // output ratio implied by N against the measured period
      meas_ratio = q.n * q.period; // R1
      ratio_err = (meas_ratio > {24'h000000, ratio_sel}) ?
         meas_ratio - {24'h000000, ratio_sel} :
         {24'h000000, ratio_sel} - meas_ratio;
      in_tol = ratio_err <= ({24'h000000, ratio_sel} >> dpl_pkg::LOCK_TOL_SH);
      // first-order loop: step toward target, bandwidth set by shift
      step = $signed({1'b0, q.target} - {1'b0, q.n}) >>> q.shift; // R16
      nsum = {1'b0, q.n} + step;

      unique case (q.state)
         dpl_pkg::ST_ACQ: begin
            if (ref_edge) begin
               d.have_prev = 1'b1;
               if (q.have_prev) begin
                  d.period = meas;
                  d.div_start = 1'b1; // R2
               end
               if (glitch) begin
                  d.good = '0;
               end
            end else if (q.since >= HOLD_L) begin
               d.have_prev = 1'b0;
               d.state = dpl_pkg::ST_EXP;
            end
         end
         dpl_pkg::ST_LOCK: begin
            if (ref_edge) begin
               if (glitch) begin
                  d.state = dpl_pkg::ST_ACQ; // R9
                  d.good = '0;
                  d.shift = dpl_pkg::ACQ_SHIFT;
               end else begin
                  d.period = meas;
                  d.div_start = 1'b1;
               end
            end else if ({1'b0, q.since} > gap_lim) begin
               d.state = dpl_pkg::ST_GAP; // R8
            end
         end
         // gap: lock and output kept while the reference is away
         dpl_pkg::ST_GAP: begin
            if (ref_edge) begin
               if (q.skip_en && (q.since < SKIP_L)) begin
                  d.state = dpl_pkg::ST_LOCK; // R6 R14 R7
               end else begin
                  d.state = dpl_pkg::ST_ACQ; // R12 R13
                  d.good = '0;
                  d.shift = dpl_pkg::ACQ_SHIFT;
               end
               d.have_prev = 1'b1;
            end else if (q.since >= HOLD_L) begin
               d.state = dpl_pkg::ST_EXP; // R10
               d.have_prev = 1'b0;
            end
         end
         // timed out: the next edge restarts acquisition
         dpl_pkg::ST_EXP: begin
            if (ref_edge) begin
               d.state = dpl_pkg::ST_ACQ; // R11
               d.have_prev = 1'b1;
               d.good = '0;
               d.shift = dpl_pkg::ACQ_SHIFT;
            end
         end
         default: begin
            d.state = dpl_pkg::ST_ACQ;
         end
      endcase

      // a fresh quotient is the desired ratio against the resonator
      if (div_done && ((q.state == dpl_pkg::ST_ACQ) ||
            (q.state == dpl_pkg::ST_LOCK))) begin
         d.target = div_quo; // R3
         d.n = nsum[31:0]; // R1
         if (q.state == dpl_pkg::ST_ACQ) begin
            d.shift = dpl_pkg::ACQ_SHIFT; // R17
            if (!in_tol) begin
               d.good = '0;
            end else if (q.good == dpl_pkg::LOCK_GOOD - 4'h1) begin
               d.state = dpl_pkg::ST_LOCK; // R19
               d.good = '0;
            end else begin
               d.good = q.good + 4'h1;
            end
         end else if (q.shift < min_sh) begin
            d.shift = q.shift + 4'h1; // R17
         end else begin
            d.shift = min_sh; // R15
         end
      end

      // only the ratio and set change with the mode, not the globals
      if (q.mode_s != q.mode_prev) begin
         d.state = dpl_pkg::ST_ACQ; // R4 R5
         d.good = '0;
         d.shift = dpl_pkg::ACQ_SHIFT;
      end

      d.locked = (d.state == dpl_pkg::ST_LOCK) ||
         (d.state == dpl_pkg::ST_GAP);
      d.out_en = d.locked || q.owu; // R10 R12 R13

      // apb slave: ready and read data in the first access cycle
      cfg_word = '0;
      cfg_word[dpl_pkg::CFG_SKIP_BIT] = q.skip_en;
      cfg_word[dpl_pkg::CFG_OWU_BIT] = q.owu;
      cfg_word[dpl_pkg::CFG_BW_LSB +: dpl_pkg::BW_W] = q.bw_sel;
      status = '0;
      status[dpl_pkg::ST_LOCK_BIT] = q.locked;
      status[dpl_pkg::ST_OUT_BIT] = q.out_en;
      status[dpl_pkg::ST_MODE_LSB +: 2] = q.mode_s;
      status[dpl_pkg::ST_STATE_LSB +: 4] = q.state;
      status[dpl_pkg::ST_SHIFT_LSB +: 4] = q.shift;
      d.pready = PSEL_I & ~PENABLE_I;
      d.pslverr = PSEL_I & ~PENABLE_I & ~mapped(PADDR_I);
      d.prdata = '0;
      if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
         unique case (PADDR_I)
            dpl_pkg::OFF_CFG: d.prdata = cfg_word;
            dpl_pkg::OFF_RATIO0: d.prdata = q.ratio[0];
            dpl_pkg::OFF_RATIO1: d.prdata = q.ratio[1];
            dpl_pkg::OFF_RATIO2: d.prdata = q.ratio[2];
            dpl_pkg::OFF_RATIO3: d.prdata = q.ratio[3];
            dpl_pkg::OFF_STATUS: d.prdata = status;
            dpl_pkg::OFF_NVAL: d.prdata = q.n;
            dpl_pkg::OFF_PERIOD: d.prdata = {8'h00, q.period};
            default: d.prdata = '0;
         endcase
      end
      if (PSEL_I && PENABLE_I && q.pready && PWRITE_I) begin
         unique case (PADDR_I)
            dpl_pkg::OFF_CFG: begin
               d.skip_en = PWDATA_I[dpl_pkg::CFG_SKIP_BIT];
               d.owu = PWDATA_I[dpl_pkg::CFG_OWU_BIT];
               d.bw_sel = PWDATA_I[dpl_pkg::CFG_BW_LSB +: dpl_pkg::BW_W];
            end
            dpl_pkg::OFF_RATIO0: d.ratio[0] = PWDATA_I;
            dpl_pkg::OFF_RATIO1: d.ratio[1] = PWDATA_I;
            dpl_pkg::OFF_RATIO2: d.ratio[2] = PWDATA_I;
            dpl_pkg::OFF_RATIO3: d.ratio[3] = PWDATA_I;
            default: begin
            end
         endcase
      end
   end

   // reset: acquire, every stored ratio at its default
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         q <= '0;
         q.state <= dpl_pkg::ST_ACQ;
         q.ratio <= {4{dpl_pkg::RATIO_RST}};
      end else begin
         q <= d;
      end
   end

   assign PRDATA_O = q.prdata;
   assign PREADY_O = q.pready;
   assign PSLVERR_O = q.pslverr;
   assign N_VALUE_O = q.n;
   assign LOCKED_O = q.locked;
   assign OUT_EN_O = q.out_en;

endmodule : dpl_ctrl
`default_nettype wire

// [testbench/dpl_ref_src.sv]
// Purpose: reference clock source in front of the loop control block
// Assumes: period given in resonator cycles
// Notes: stays low while stopped, first edge as soon as it runs again
`timescale 1ns/1ps
`default_nettype none
module dpl_ref_src (
   input wire logic clk_i, // timebase
   input wire logic run_i, // source present
   input wire logic [15:0] period_i, // period in clk_i cycles
   output logic ref_o // reference clock
);
   logic [15:0] cnt_q;
   always_ff @(posedge clk_i) begin
      if (!run_i) begin
         cnt_q <= 16'h0000;
      end else if (cnt_q >= period_i - 16'h0001) begin
         cnt_q <= 16'h0000;
      end else begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end
   // bench keeps the period at 313 cycles or more while skipping
   assign ref_o = run_i && (cnt_q < (period_i >> 1));
endmodule : dpl_ref_src
`default_nettype wire

// [testbench/dpl_ctrl_props.sv]
// Purpose: port checks of the loop control block
// Assumes: bound to dpl_ctrl from the bench top
// Notes: cycles since the last raw reference edge kept in gap_q
`timescale 1ns/1ps
`default_nettype none
module dpl_ctrl_props #(
   parameter int unsigned HOLD_CYCLES = 2000,
   parameter int unsigned SKIP_CYCLES = 500
) (
   input wire logic CLK_I, // clock
   input wire logic SRST_I, // reset
   input wire logic REF_CLK_I, // reference
   input wire logic [1:0] MODE_SEL_I, // mode pins
   input wire logic PSEL_I, // apb
   input wire logic PENABLE_I, // apb
   input wire logic PWRITE_I, // apb
   input wire logic [7:0] PADDR_I, // apb
   input wire logic [31:0] PWDATA_I, // apb
   input wire logic [31:0] PRDATA_O, // apb
   input wire logic PREADY_O, // apb
   input wire logic PSLVERR_O, // apb
   input wire logic [31:0] N_VALUE_O, // divide value
   input wire logic LOCKED_O, // lock
   input wire logic OUT_EN_O // output enable
);
   logic ref_q;
   logic owu_q;
   logic owu_p;
   logic [15:0] gap_q;
   always_ff @(posedge CLK_I) begin
      ref_q <= REF_CLK_I;
      owu_p <= owu_q;
      if (SRST_I) begin
         owu_q <= 1'b0;
         gap_q <= 16'h0000;
      end else begin
         if (PSEL_I && PENABLE_I && PREADY_O && PWRITE_I &&
             PADDR_I == dpl_pkg::OFF_CFG) begin
            owu_q <= PWDATA_I[dpl_pkg::CFG_OWU_BIT];
         end
         if (REF_CLK_I && !ref_q) begin
            gap_q <= 16'h0000;
         end else if (gap_q != 16'hffff) begin
            gap_q <= gap_q + 16'h0001;
         end
      end
   end
   default clocking @(posedge CLK_I); endclocking
   default disable iff (SRST_I);
   a_ready_pulse: assert property (PSEL_I && !PENABLE_I |=>
      PREADY_O ##1 !PREADY_O) else $error("ready not a single pulse");
   a_err_unmapped: assert property (PREADY_O && PADDR_I[7:5] != 3'h0
      |-> PSLVERR_O && PRDATA_O == 32'h0) else $error("unmapped access");
   a_rdata_idle: assert property (!PREADY_O |->
      PRDATA_O == 32'h0 && !PSLVERR_O) else $error("idle bus not quiet");
   a_lock_out: assert property (LOCKED_O |-> OUT_EN_O)
      else $error("locked without output");
   a_unlock_out: assert property (!LOCKED_O && owu_q == owu_p
      |-> OUT_EN_O == owu_q) else $error("unlocked output wrong");
   a_hold_expire: assert property (gap_q > HOLD_CYCLES + 8
      |-> !LOCKED_O) else $error("lock held past timeout");
   a_lock_rise: assert property ($rose(LOCKED_O)
      |-> gap_q <= 16'h0030) else $error("lock not tied to edge");
   a_n_update: assert property ($changed(N_VALUE_O)
      |-> gap_q <= 16'h0030) else $error("divide value moved late");
   a_mode_drop: assert property ($changed(MODE_SEL_I)
      |-> ##[1:8] !LOCKED_O) else $error("mode change kept lock");
   c_lock: cover property ($rose(LOCKED_O));
   c_unlock: cover property ($fell(LOCKED_O));
   c_gap: cover property (LOCKED_O && gap_q > 16'h02bc);
   c_err: cover property (PREADY_O && PSLVERR_O);
endmodule : dpl_ctrl_props
`default_nettype wire

// [testbench/test_digital_pll_lock_and_skip_control.sv]
// Purpose: self-checking bench of the loop control block
// Assumes: reference source model, short hold and skip counts
// Notes: registers over APB, four gap cases of three lengths
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
$display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module test_digital_pll_lock_and_skip_control;
   localparam int unsigned HOLD = 4000;
   localparam int unsigned SKIP = 1200;
   localparam int P = 400;
   logic clk, srst, run, psel, pen, pwr, pready, pslverr, locked, out_en;
   logic ref_clk, er;
   logic [1:0] mode;
   logic [2:0] bw;
   logic [7:0] paddr;
   logic [15:0] per;
   logic [31:0] pwdata, prdata, nval, rd_v, cfg;
   logic [31:0] ratio [4];
   int n_errors, compares, i;
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   dpl_ref_src u_dpl_ref_src (.clk_i(clk), .run_i(run), .period_i(per),
      .ref_o(ref_clk));
   dpl_ctrl #(.HOLD_CYCLES(HOLD), .SKIP_CYCLES(SKIP)) u_dpl_ctrl (
      .CLK_I(clk), .SRST_I(srst), .REF_CLK_I(ref_clk), .MODE_SEL_I(mode),
      .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
      .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .N_VALUE_O(nval), .LOCKED_O(locked),
      .OUT_EN_O(out_en));
   task end_of_test;
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_of_test
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      // ready, read data and error all taken at the same rising edge
      @(posedge clk);
      for (k = 1; k < 20 && pready !== 1'b1; k++) @(posedge clk);
      if (pready !== 1'b1) begin
         n_errors++;
         end_of_test;
      end
      rd_v = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task wait_lock(input int bound);
      int k;
      for (k = 0; k < bound && locked !== 1'b1; k++) @(negedge clk);
      if (locked !== 1'b1) begin
         n_errors++;
         end_of_test;
      end
   endtask : wait_lock
   function automatic logic [31:0] exp_n(input logic [31:0] r);
      return r / P;
   endfunction : exp_n
   task gap_case(input int len, input logic skip, input logic owu,
                 input logic drop_g, input logic drop_a);
      int k;
      logic fg, fa, bad;
      fg = 1'b0;
      fa = 1'b0;
      bad = 1'b0;
      apb(1'b1, dpl_pkg::OFF_CFG, {25'h0, bw, 2'h0, owu, skip});
      wait_lock(200 * P);
      for (k = 0; k < 2 * P && ref_clk !== 1'b0; k++) @(posedge clk);
      for (k = 0; k < 2 * P && ref_clk !== 1'b1; k++) @(posedge clk);
      if (ref_clk !== 1'b1) begin
         n_errors++;
         end_of_test;
      end
      run <= 1'b0;
      for (k = 0; k < len + 2 * P; k++) begin
         if (k == len) @(posedge clk) run <= 1'b1;
         @(negedge clk);
         if (locked !== 1'b1 && k < len) fg = 1'b1;
         if (locked !== 1'b1 && k >= len) fa = 1'b1;
         if (locked === 1'b0 && out_en !== owu) bad = 1'b1;
      end
      `CHK(fg, drop_g)
      `CHK(fa, drop_a)
      `CHK(bad, 1'b0)
      wait_lock(200 * P + HOLD);
      $display("gap test %0d done", len);
   endtask : gap_case
   initial begin
      srst = 1'b1;
      run = 1'b0;
      per = 16'(P);
      mode = 2'h0;
      psel = 1'b0;
      pen = 1'b0;
      pwr = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      n_errors = 0;
      compares = 0;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      rd_v = $urandom(35);
      apb(1'b0, dpl_pkg::OFF_CFG, 32'h0);
      `CHK(rd_v, 32'h0)
      for (i = 0; i < 4; i++) begin
         apb(1'b0, dpl_pkg::OFF_RATIO0 + 8'(4 * i), 32'h0);
         `CHK(rd_v, dpl_pkg::RATIO_RST)
      end
      apb(1'b0, dpl_pkg::OFF_STATUS, 32'h0);
      `CHK(rd_v, 32'h0000_0010)
      apb(1'b0, 8'h20, 32'h0);
      `CHK(er, 1'b1)
      $display("register test done");
      bw = 3'($urandom % 8);
      cfg = {25'h0, bw, 4'h0};
      apb(1'b1, dpl_pkg::OFF_CFG, cfg);
      for (i = 0; i < 4; i++) begin
         ratio[i] = 32'h0010_0000 + ($urandom & 32'h00ff_ffff);
         apb(1'b1, dpl_pkg::OFF_RATIO0 + 8'(4 * i), ratio[i]);
      end
      @(posedge clk) run <= 1'b1;
      for (i = 3; i >= 0; i--) begin
         @(posedge clk) mode <= 2'(i);
         repeat (10) @(posedge clk);
         wait_lock(200 * P + P);
         `CHK(nval, exp_n(ratio[i]))
         repeat (10 * P) @(posedge clk);
         apb(1'b0, dpl_pkg::OFF_STATUS, 32'h0);
         `CHK(rd_v[11:8], 4'h8 - {1'b0, bw})
         `CHK(rd_v[3:2], 2'(i))
      end
      apb(1'b0, dpl_pkg::OFF_CFG, 32'h0);
      `CHK(rd_v, cfg)
      $display("mode test done");
      gap_case(900, 1'b1, 1'b0, 1'b0, 1'b0);
      gap_case(900, 1'b0, 1'b1, 1'b0, 1'b1);
      gap_case(2500, 1'b1, 1'b1, 1'b0, 1'b1);
      gap_case(5000, 1'b0, 1'b0, 1'b1, 1'b1);
      @(posedge clk) per <= 16'd300;
      for (i = 0; i < 2 * P && locked === 1'b1; i++) @(negedge clk);
      `CHK(locked, 1'b0)
      $display("period change test done");
      end_of_test;
   end
endmodule : test_digital_pll_lock_and_skip_control
bind dpl_ctrl dpl_ctrl_props #(.HOLD_CYCLES(HOLD_CYCLES),
   .SKIP_CYCLES(SKIP_CYCLES)) u_dpl_ctrl_props (.CLK_I(CLK_I),
   .SRST_I(SRST_I), .REF_CLK_I(REF_CLK_I), .MODE_SEL_I(MODE_SEL_I),
   .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
   .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
   .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .N_VALUE_O(N_VALUE_O),
   .LOCKED_O(LOCKED_O), .OUT_EN_O(OUT_EN_O));
`default_nettype wire
